/* File: dv/fdio_checker_assertions.sv */
`default_nettype none
module fdio_checker
  import fdio_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        eeprom_load,
  input wire logic [7:0]  eeprom_cfg,
  input wire logic [15:0] eeprom_ext_cfg,
  input wire logic        frame_start,
  input wire logic        frame_end,
  input wire logic        frame_wd_hit,
  input wire logic        sync_event_0,
  input wire logic        sync_event_1,
  input wire logic        wd_trigger,
  input wire logic        wd_expired,
  input wire logic        external_output_enable,
  input wire logic [15:0] user_io_pins_out,
  input wire logic [15:0] user_io_pins_oe,
  input wire logic        output_valid,
  input wire logic        watchdog_trigger_pulse,
  input wire logic        sof_strobe,
  input wire logic        eof_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // shadow of loaded configuration
  // ------------------------------------------------------------
  logic [7:0]  cfg_ff;
  logic [7:0]  dir_ff;
  logic        s0_ff;
  logic        s1_ff;
  logic        trig;
  logic        act;
  logic [15:0] dir_pins;
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_ff <= CFG_RESET;
      dir_ff <= 8'h00;
    end else if (eeprom_load) begin
      cfg_ff <= eeprom_cfg;
      dir_ff <= eeprom_ext_cfg[7:0];
    end
  end
  always_ff @(posedge clock) begin
    s0_ff <= sync_event_0;
    s1_ff <= sync_event_1;
  end
  always_comb begin
    for (int i = 0; i < NUM_PAIRS; i++) begin
      dir_pins[2*i +: 2] = {2{dir_ff[i]}};
    end
  end
  always_comb begin
    case (cfg_ff[CFG_OUT_SEL_HI:CFG_OUT_SEL_LO])
      OSEL_EOF:   trig = frame_end;
      OSEL_SYNC_EVENT_0: trig = sync_event_0 & ~s0_ff;
      OSEL_SYNC_EVENT_1: trig = sync_event_1 & ~s1_ff;
      default:    trig = frame_end & frame_wd_hit;
    endcase
  end
  // mode bit mixes the trigger in, so strobe checks skip that mode
  assign act = (output_valid == cfg_ff[CFG_OV_POL]);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  eof_width_a: assert property (frame_end |=> eof_strobe ##1 !eof_strobe)
    else $error("end strobe width wrong");
  sof_width_a: assert property (frame_start |=> sof_strobe ##1 !sof_strobe)
    else $error("start strobe width wrong");
  trig_pulse_a: assert property (wd_trigger
    |=> watchdog_trigger_pulse ##1 !watchdog_trigger_pulse)
    else $error("trigger pulse wrong");
  ext_off_a: assert property (!external_output_enable
    |=> user_io_pins_out == 16'h0000)
    else $error("pins not low on enable");
  pair_dir_a: assert property (!cfg_ff[CFG_BIDIR] && !eeprom_load
    |=> user_io_pins_oe == dir_pins)
    else $error("pin direction wrong");
  ov_width_a: assert property ($rose(act) && $stable(cfg_ff) && !cfg_ff[CFG_OV_MODE]
    |=> act ##1 !act)
    else $error("valid width wrong");
  ov_setup_a: assert property ($rose(act) && $stable(cfg_ff) && !cfg_ff[CFG_OV_MODE]
    |-> $past(user_io_pins_out, 2) == user_io_pins_out)
    else $error("data setup short");
  ov_hold_a: assert property ($fell(act) && $stable(cfg_ff) && !cfg_ff[CFG_OV_MODE]
    |=> $stable(user_io_pins_out) [*2])
    else $error("data hold short");
  // trigger edge, two setup cycles, then the registered strobe: four clocks
  ov_cause_a: assert property ($rose(act) && $stable(cfg_ff) && !cfg_ff[CFG_OV_MODE]
    |-> $past(trig, 4))
    else $error("valid without trigger");
  wd_now_a: assert property (wd_expired && $past(wd_expired)
    && $past(wd_expired, 2) && !cfg_ff[CFG_WD_DEFER] && $stable(cfg_ff)
    |-> user_io_pins_out == 16'h0000)
    else $error("pins not reset on expiry");
endmodule // fdio_checker
`default_nettype wire

/* File: dv/fdio_io_model.sv */
`default_nettype none
module fdio_io_model
  import fdio_pkg::*;
(
  input  wire logic [15:0] pins_out,
  input  wire logic [15:0] pins_oe,
  input  wire logic [15:0] far_val,
  output logic      [15:0] pins_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // pin resolution
  // ------------------------------------------------------------
  // far side holds its value until the bench changes it
  assign pins_in = (pins_oe & pins_out) | (~pins_oe & far_val);
endmodule // fdio_io_model
`default_nettype wire

/* File: dv/fdio_top_bench.sv */
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module fdio_top_bench
  import fdio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        eeprom_load, frame_start, frame_end, frame_wd_hit, latch_in;
  logic        sync_event_0, sync_event_1, wd_trigger, wd_expired;
  logic        external_output_enable, output_valid, watchdog_trigger_pulse;
  logic        sof_strobe, eof_strobe;
  logic [7:0]  eeprom_cfg;
  logic [15:0] eeprom_ext_cfg, pins_in, user_io_pins_out, user_io_pins_oe, far_val;
  int          err_count, checked, m_pins;
  int          kt[4] = '{4, 2, 3, 5};
  assign hready = hreadyout;
  fdio_top DUT (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .eeprom_load, .eeprom_cfg, .eeprom_ext_cfg,
    .frame_start, .frame_end, .frame_wd_hit, .sync_event_0, .sync_event_1, .latch_in,
    .wd_trigger, .wd_expired, .external_output_enable, .user_io_pins_in(pins_in),
    .user_io_pins_out, .user_io_pins_oe, .output_valid, .watchdog_trigger_pulse,
    .sof_strobe, .eof_strobe);
  fdio_io_model u_far (.pins_out(user_io_pins_out), .pins_oe(user_io_pins_oe),
    .far_val, .pins_in);
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic ev(input int k);
    @(posedge clock);
    case (k)
      0: frame_start <= 1'b1;
      1: latch_in <= 1'b1;
      2: sync_event_0 <= 1'b1;
      3: sync_event_1 <= 1'b1;
      default: frame_end <= 1'b1;
    endcase
    frame_wd_hit <= (k == 5);
    @(posedge clock);
    {frame_start, latch_in, sync_event_0, sync_event_1, frame_end, frame_wd_hit} <= 6'h00;
  endtask
  task automatic load(input logic [7:0] c, input logic [15:0] e);
    @(posedge clock);
    eeprom_cfg <= c;
    eeprom_ext_cfg <= e;
    eeprom_load <= 1'b1;
    @(posedge clock);
    eeprom_load <= 1'b0;
  endtask
  task automatic out_ev(input int k, input logic [15:0] d);
    bus(1'b1, ADDR_OUT_DATA, {16'h0000, d});
    ev(k);
    repeat (12) @(negedge clock);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // clock, watchdog, tests
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    repeat (6000) @(posedge clock);
    err_count++;
    report_and_stop();
  end
  initial begin
    {hsel, hwrite, eeprom_load, frame_start, frame_end, frame_wd_hit, latch_in} = '0;
    {sync_event_0, sync_event_1, wd_trigger, wd_expired, htrans} = '0;
    {haddr, hwdata, eeprom_cfg, eeprom_ext_cfg, far_val, err_count, checked} = '0;
    hsize = 3'h2;
    external_output_enable = 1'b1;
    rst = 1'b1;
    rd = $urandom(32'h79629610);
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      `CHK(rd, (i == 4) ? 32'h8 : 32'h0)
    end
    bus(1'b1, ADDR_CFG, 32'hff);
    bus(1'b0, ADDR_CFG, 32'h0);
    `CHK(rd, 32'h0)
    $display("test 1 done");
    for (int s = 0; s < 4; s++) begin
      load({2'(s), 4'h0, 2'(s)}, 16'h00ff);
      m_pins = 16'($urandom());
      out_ev(kt[s], 16'(m_pins));
      `CHK(user_io_pins_out, 16'(m_pins))
      `CHK(user_io_pins_oe, 16'hffff)
      `CHK(output_valid, ~1'(s))
      @(posedge clock);
      wd_trigger <= 1'b1;
      @(posedge clock);
      wd_trigger <= 1'b0;
      @(negedge clock);
      `CHK(watchdog_trigger_pulse, 1'b1)
      `CHK(output_valid, 1'(s) ^ 1'(s < 2))
    end
    out_ev(4, 16'(~m_pins));
    `CHK(user_io_pins_out, 16'(m_pins))
    $display("test 2 done");
    for (int s = 0; s < 4; s++) begin
      load({2'h0, 2'(s), 4'h0}, 16'h0005);
      far_val <= 16'($urandom());
      ev(s);
      repeat (12) @(negedge clock);
      `CHK(user_io_pins_oe, 16'h0033)
      bus(1'b0, ADDR_IN_DATA, 32'h0);
      `CHK(rd[15:0], (16'h0033 & 16'(m_pins)) | (16'hffcc & far_val))
    end
    $display("test 3 done");
    load(8'h00, 16'h00ff);
    bus(1'b1, ADDR_OUT_DATA, 32'h00001234);
    ev(4);
    out_ev(4, 16'h4321);
    `CHK(user_io_pins_out, 16'h1234)
    out_ev(4, 16'h4321);
    `CHK(user_io_pins_out, 16'h4321)
    $display("test 4 done");
    for (int dfr = 0; dfr < 2; dfr++) begin
      load({4'h0, 1'(dfr), 3'h0}, 16'h00ff);
      m_pins = 16'($urandom()) | 1;
      out_ev(4, 16'(m_pins));
      @(posedge clock);
      wd_expired <= 1'b1;
      repeat (4) @(negedge clock);
      `CHK(user_io_pins_out, dfr ? 16'(m_pins) : 16'h0000)
      out_ev(4, 16'h0f0f);
      `CHK(user_io_pins_out, 16'h0000)
      @(posedge clock);
      wd_expired <= 1'b0;
    end
    m_pins = 16'($urandom()) | 1;
    out_ev(4, 16'(m_pins));
    `CHK(user_io_pins_out, 16'(m_pins))
    @(posedge clock);
    external_output_enable <= 1'b0;
    repeat (3) @(negedge clock);
    `CHK(user_io_pins_out, 16'h0000)
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[3:2], 2'b00)
    external_output_enable <= 1'b1;
    $display("test 5 done");
    load(8'h04, 16'h00ff);
    bus(1'b1, ADDR_OUT_DATA, 32'h0000a5c3);
    ev(4);
    repeat (4) @(negedge clock);
    `CHK(user_io_pins_oe, 16'hffff)
    `CHK(user_io_pins_out, 16'ha5c3)
    repeat (10) @(negedge clock);
    `CHK(user_io_pins_oe, 16'h0000)
    @(posedge clock);
    far_val <= 16'($urandom());
    ev(0);
    repeat (12) @(negedge clock);
    bus(1'b0, ADDR_IN_DATA, 32'h0);
    `CHK(rd[15:0], far_val)
    $display("test 6 done");
    report_and_stop();
  end
endmodule // fdio_top_bench
bind fdio_top fdio_checker u_chk (.clock, .rst, .hreadyout, .hresp, .eeprom_load,
  .eeprom_cfg, .eeprom_ext_cfg, .frame_end, .frame_wd_hit, .sync_event_0, .sync_event_1,
  .wd_trigger, .wd_expired, .external_output_enable, .user_io_pins_out, .user_io_pins_oe,
  .output_valid, .watchdog_trigger_pulse, .eof_strobe, .frame_start, .sof_strobe);
`default_nettype wire

/* File: logic/fdio_ahb_slave.sv */
`default_nettype none
module fdio_ahb_slave
  import fdio_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data
);
  logic       wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic       take;

  // only word transfers are used; hsize is accepted but not checked
  assign take    = hsel & htrans[1] & hready;
  assign rd_addr = haddr[7:0];
  assign wr_en   = wr_pend_ff;
  assign wr_addr = wr_addr_ff;
  assign wr_data = hwdata;

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= take & hwrite;
      wr_addr_ff <= haddr[7:0];
    end
  end

  // read data sampled at the address phase, so zero wait states
  always_ff @(posedge clock) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (take & ~hwrite) begin
      hrdata <= rd_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule // fdio_ahb_slave
`default_nettype wire

/* File: logic/fdio_gap_guard.sv */
`default_nettype none
module fdio_gap_guard
  import fdio_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       take,
  input  wire logic [3:0] min_cyc,
  output logic            free
);
  logic [3:0] cnt_ff;

  // counts from an accepted event; next one waits till zero
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_ff <= 4'h0;
    end else if (take) begin
      cnt_ff <= 4'(min_cyc - 4'h1);
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= 4'(cnt_ff - 4'h1);
    end
  end

  assign free = (cnt_ff == 4'h0);
endmodule // fdio_gap_guard
`default_nettype wire

/* File: logic/fdio_pkg.sv */
`default_nettype none
package fdio_pkg;
  // ----------------------------------------------------------
  // register map
  // ----------------------------------------------------------
  localparam logic [7:0]  ADDR_OUT_DATA = 8'h00;
  localparam logic [7:0]  ADDR_IN_DATA  = 8'h04;
  localparam logic [7:0]  ADDR_CFG      = 8'h08;
  localparam logic [7:0]  ADDR_EXT_CFG  = 8'h0c;
  localparam logic [7:0]  ADDR_STATUS   = 8'h10;
  // ----------------------------------------------------------
  // configuration byte fields
  // ----------------------------------------------------------
  localparam int          CFG_OUT_SEL_HI = 7;
  localparam int          CFG_OUT_SEL_LO = 6;
  localparam int          CFG_IN_SEL_HI  = 5;
  localparam int          CFG_IN_SEL_LO  = 4;
  localparam int          CFG_WD_DEFER   = 3;
  localparam int          CFG_BIDIR      = 2;
  localparam int          CFG_OV_MODE    = 1;
  localparam int          CFG_OV_POL     = 0;
  localparam int          NUM_PINS       = 16;
  localparam int          NUM_PAIRS      = 8;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic [15:0] EXT_RESET      = 16'h0000;
  localparam logic [1:0]  OSEL_EOF       = 2'h0;
  localparam logic [1:0]  OSEL_SYNC_EVENT_0     = 2'h1;
  localparam logic [1:0]  OSEL_SYNC_EVENT_1     = 2'h2;
  localparam logic [1:0]  OSEL_WD_EOF    = 2'h3;
  localparam logic [1:0]  ISEL_SOF       = 2'h0;
  localparam logic [1:0]  ISEL_LATCH     = 2'h1;
  localparam logic [1:0]  ISEL_SYNC_EVENT_0     = 2'h2;
  localparam logic [1:0]  ISEL_SYNC_EVENT_1     = 2'h3;
  // ----------------------------------------------------------
  // timing
  // ----------------------------------------------------------
  localparam int          CLK_NS         = 50;
  localparam int          OUT_SETUP_NS   = 65;
  localparam int          OUT_HOLD_NS    = 65;
  localparam int          OUTVALID_NS    = 75;
  localparam int          OUT_GAP_NS     = 320;
  localparam int          IN_GAP_NS      = 440;
  localparam logic [3:0]  SETUP_CYC  = 4'((OUT_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  HOLD_CYC   = 4'((OUT_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  VALID_CYC  = 4'((OUTVALID_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  OUT_GAP_CYC = 4'((OUT_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  IN_GAP_CYC  = 4'((IN_GAP_NS + CLK_NS - 1) / CLK_NS);
  // ----------------------------------------------------------
  // output sequence states
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_VALID = 2'b10,
    ST_HOLD  = 2'b11
  } fdio_state_type;
endpackage
`default_nettype wire

/* File: logic/fdio_top.sv */
`default_nettype none
module fdio_top
  import fdio_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        eeprom_load,
  input  wire logic [7:0]  eeprom_cfg,
  input  wire logic [15:0] eeprom_ext_cfg,
  input  wire logic        frame_start,
  input  wire logic        frame_end,
  input  wire logic        frame_wd_hit,
  input  wire logic        sync_event_0,
  input  wire logic        sync_event_1,
  input  wire logic        latch_in,
  input  wire logic        wd_trigger,
  input  wire logic        wd_expired,
  input  wire logic        external_output_enable,
  input  wire logic [15:0] user_io_pins_in,
  output logic [15:0]      user_io_pins_out,
  output logic [15:0]      user_io_pins_oe,
  output logic             output_valid,
  output logic             watchdog_trigger_pulse,
  output logic             sof_strobe,
  output logic             eof_strobe
);
  // ----------------------------------------------------------
  // declarations
  // ----------------------------------------------------------
  logic [7:0]     cfg_ff;
  logic [15:0]    ext_ff;
  logic [15:0]    out_reg_ff;
  logic [15:0]    in_data_ff;
  logic [15:0]    pin_val_ff;
  logic           sync_event_0_d_ff;
  logic           sync_event_1_d_ff;
  logic           latch_d_ff;
  fdio_state_type state_ff;
  fdio_state_type nxt_state;
  logic [3:0]     cnt_ff;
  logic [3:0]     nxt_cnt;
  logic [7:0]     rd_addr;
  logic [31:0]    rd_data;
  logic           wr_en;
  logic [7:0]     wr_addr;
  logic [31:0]    wr_data;
  logic           bidir;
  logic           sync_event_0_rise;
  logic           sync_event_1_rise;
  logic           latch_rise;
  logic           out_req;
  logic           in_req;
  logic           out_free;
  logic           in_free;
  logic           out_take;
  logic           in_take;
  logic [3:0]     gap_out;
  logic [3:0]     gap_in;
  logic [15:0]    nxt_oe;
  logic           ov_active;

  // ----------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------
  fdio_ahb_slave u_bus (
    .clock     (clock),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data)
  );

  always_comb begin
    unique case (rd_addr)
      ADDR_OUT_DATA: rd_data = {16'h0000, out_reg_ff};
      ADDR_IN_DATA:  rd_data = {16'h0000, in_data_ff};
      ADDR_CFG:      rd_data = {24'h000000, cfg_ff};
      ADDR_EXT_CFG:  rd_data = {16'h0000, ext_ff};
      ADDR_STATUS:   rd_data = {28'h0000000, external_output_enable,
                                wd_expired, state_ff};
      default:       rd_data = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  // configuration is read-only to software; only the eeprom loads it
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_ff <= CFG_RESET;
      ext_ff <= EXT_RESET;
    end else if (eeprom_load) begin
      cfg_ff <= eeprom_cfg;
      ext_ff <= eeprom_ext_cfg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      out_reg_ff <= 16'h0000;
    end else if (wr_en && wr_addr == ADDR_OUT_DATA) begin
      out_reg_ff <= wr_data[15:0];
    end
  end

  assign bidir = cfg_ff[CFG_BIDIR];

  // ----------------------------------------------------------
  // event selection
  // ----------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      sync_event_0_d_ff <= 1'b0;
      sync_event_1_d_ff <= 1'b0;
      latch_d_ff <= 1'b0;
    end else begin
      sync_event_0_d_ff <= sync_event_0;
      sync_event_1_d_ff <= sync_event_1;
      latch_d_ff <= latch_in;
    end
  end

  assign sync_event_0_rise = sync_event_0 & ~sync_event_0_d_ff;
  assign sync_event_1_rise = sync_event_1 & ~sync_event_1_d_ff;
  assign latch_rise = latch_in & ~latch_d_ff;

  always_comb begin
    unique case (cfg_ff[CFG_OUT_SEL_HI:CFG_OUT_SEL_LO])
      OSEL_EOF:    out_req = frame_end;
      OSEL_SYNC_EVENT_0:  out_req = sync_event_0_rise;
      OSEL_SYNC_EVENT_1:  out_req = sync_event_1_rise;
      OSEL_WD_EOF: out_req = frame_end & frame_wd_hit;
    endcase
  end

  always_comb begin
    unique case (cfg_ff[CFG_IN_SEL_HI:CFG_IN_SEL_LO])
      ISEL_SOF:   in_req = frame_start;
      ISEL_LATCH: in_req = latch_rise;
      ISEL_SYNC_EVENT_0: in_req = sync_event_0_rise;
      ISEL_SYNC_EVENT_1: in_req = sync_event_1_rise;
    endcase
  end

  // ----------------------------------------------------------
  // event spacing
  // ----------------------------------------------------------
  // too-close events are dropped rather than queued
  assign gap_out  = bidir ? IN_GAP_CYC : OUT_GAP_CYC;
  assign gap_in   = IN_GAP_CYC;
  assign out_take = out_req & out_free & (~bidir | in_free);
  // in bidir mode outputs win a tie and pins must be released first
  assign in_take  = in_req & in_free & (~bidir | (out_free & ~out_take
                    & state_ff == ST_IDLE & ~|user_io_pins_oe));

  fdio_gap_guard u_gap_out (
    .clock   (clock),
    .rst     (rst),
    .take    (out_take | (bidir & in_take)),
    .min_cyc (gap_out),
    .free    (out_free)
  );

  fdio_gap_guard u_gap_in (
    .clock   (clock),
    .rst     (rst),
    .take    (in_take | (bidir & out_take)),
    .min_cyc (gap_in),
    .free    (in_free)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      in_data_ff <= 16'h0000;
    end else if (in_take) begin
      in_data_ff <= user_io_pins_in;
    end
  end

  // ----------------------------------------------------------
  // output data and watchdog reset
  // ----------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_val_ff <= 16'h0000;
    end else if (out_take) begin
      pin_val_ff <= wd_expired ? 16'h0000 : out_reg_ff;
    end else if (wd_expired && !cfg_ff[CFG_WD_DEFER]) begin
      pin_val_ff <= 16'h0000;
    end
  end

  // ----------------------------------------------------------
  // output strobe sequence
  // ----------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (out_take) begin
          nxt_state = ST_SETUP;
          nxt_cnt   = 4'(SETUP_CYC - 4'h1);
        end
      end
      ST_SETUP: begin
        if (cnt_ff == 4'h0) begin
          nxt_state = ST_VALID;
          nxt_cnt   = 4'(VALID_CYC - 4'h1);
        end else begin
          nxt_cnt = 4'(cnt_ff - 4'h1);
        end
      end
      ST_VALID: begin
        if (cnt_ff == 4'h0) begin
          nxt_state = ST_HOLD;
          nxt_cnt   = 4'(HOLD_CYC - 4'h1);
        end else begin
          nxt_cnt = 4'(cnt_ff - 4'h1);
        end
      end
      ST_HOLD: begin
        if (cnt_ff == 4'h0) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_cnt = 4'(cnt_ff - 4'h1);
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------
  // bidir drives every pin only while the strobe sequence runs
  generate
    for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
      assign nxt_oe[2*p+1:2*p] = bidir ? {2{state_ff != ST_IDLE}}
                                       : {2{ext_ff[p]}};
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst) begin
      user_io_pins_oe  <= 16'h0000;
      user_io_pins_out <= 16'h0000;
    end else begin
      user_io_pins_oe  <= nxt_oe;
      user_io_pins_out <= external_output_enable ? pin_val_ff
                                                 : 16'h0000;
    end
  end

  // ----------------------------------------------------------
  // strobes
  // ----------------------------------------------------------
  assign ov_active = (state_ff == ST_VALID)
                   | (cfg_ff[CFG_OV_MODE] & wd_trigger);

  // one clock is the shortest whole-cycle width at this rate
  always_ff @(posedge clock) begin
    if (rst) begin
      output_valid           <= 1'b0;
      watchdog_trigger_pulse <= 1'b0;
      sof_strobe             <= 1'b0;
      eof_strobe             <= 1'b0;
    end else begin
      output_valid           <= ~(ov_active ^ cfg_ff[CFG_OV_POL]);
      watchdog_trigger_pulse <= wd_trigger;
      sof_strobe             <= frame_start;
      eof_strobe             <= frame_end;
    end
  end
endmodule // fdio_top
`default_nettype wire
